//--- core/plm_monitor.sv
/*
  Process overload, stall and pulse frequency monitor with a classic
  Wishbone register slave. Assumes drive measurements arrive on the
  system clock and the pulse pins are asynchronous.
*/
// Function
// - Current limit while ramping means overload
// - Steady state current over threshold means overload
// - Steady when reference minus motor below hysteresis
// - Overload error after continuous detection time
// - Zero detection time disables overload monitoring
// - Always evaluate overload during current limitation
// - Overload threshold is percent of rated current
// - Overload reaction: ignore, freewheel, ramp, fast
// - Block restart for inhibit time after overload
// - Stall: low frequency, high current, too long
// - Stall monitoring enable, default disabled
// - Stall time limit up to 200 s
// - Stall current as percent of rated current
// - Stall frequency level, default 2.0 Hz
// - Pulse source: none, DI7 or DI8
// - Frequency is scaled reciprocal of period
// - Overspeed error after delay above threshold
// - Feedback loss on estimate versus measured mismatch
// - Brake error needs brake logic and enable
// - Brake error delayed by wear brake time
// - Speed warning level only with meter configured
module plm_monitor #(
  parameter int unsigned TICK = plm_pkg::TICK_CYC  // Cycles per control tick
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire plm_pkg::plm_msr_t msr,
  input  wire logic              pulse_di7,
  input  wire logic              pulse_di8,
  output plm_pkg::plm_flt_t      flt,
  output logic      [15:0]       meas_freq
);

  // ****************************************
  // Register slave
  // ****************************************
  localparam int NERR_W = plm_pkg::NERR;  // Sticky error count
  logic [31:0]         cfg_q [10];   // Writable words
  logic [NERR_W-1:0]   err_q;        // Sticky errors
  logic                ack_q;        // Bus acknowledge
  logic [31:0]         dat_q;        // Read data
  logic [3:0]          idx;          // Word index
  logic                wr;           // Write at the acknowledged edge

  // Merge write data under byte enables
  function automatic logic [31:0] bmerge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign idx = wb_adr_i[5:2];
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & ~|wb_adr_i[7:6];

  // Acknowledge one cycle after the request, drop it the next
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // Configuration words, written when the master sees ack
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 10; i++) begin
        cfg_q[i] <= plm_pkg::CFG_RST[i];
      end
    end else if (ce && wr && idx < plm_pkg::IX_STAT) begin
      cfg_q[idx] <= bmerge(cfg_q[idx], wb_dat_i, wb_sel_i);
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  logic        stall_en, ovs_en, fbl_en, wear_en, ovld_en;
  logic [1:0]  src, react;
  logic [7:0]  ovld_s;        // Detection time, s
  logic [15:0] ovld_thr;      // Overload threshold, 0.1 %
  logic [15:0] inh_lim;       // Inhibit time, ticks
  logic [15:0] hyst;          // Steady band, 0.1 Hz
  logic [9:0]  sdiv;          // Divider, tenths

  assign stall_en = cfg_q[plm_pkg::IX_CTRL][plm_pkg::C_STALL_EN];
  assign ovs_en   = cfg_q[plm_pkg::IX_CTRL][plm_pkg::C_OVS_EN];
  assign fbl_en   = cfg_q[plm_pkg::IX_CTRL][plm_pkg::C_FBL_EN];
  assign wear_en  = cfg_q[plm_pkg::IX_CTRL][plm_pkg::C_WEAR_EN];
  assign src      = cfg_q[plm_pkg::IX_CTRL][plm_pkg::C_SRC +: 2];
  assign react    = cfg_q[plm_pkg::IX_CTRL][plm_pkg::C_REACT +: 2];
  assign ovld_s   = cfg_q[plm_pkg::IX_OVLD][7:0];
  assign ovld_en  = |ovld_s;
  assign ovld_thr = 16'(cfg_q[plm_pkg::IX_OVLD][15:8] * 10);
  assign inh_lim  = 16'(cfg_q[plm_pkg::IX_OVLD][19:16] * plm_pkg::TPM);
  assign hyst     = cfg_q[plm_pkg::IX_HYST][15:0];
  assign sdiv     = (cfg_q[plm_pkg::IX_DIV][9:0] < 10'h00a) ? 10'h00a
                  : cfg_q[plm_pkg::IX_DIV][9:0];

  // ****************************************
  // Control tick
  // ****************************************
  logic [31:0] tk_q;   // Tick divider
  logic        tick;   // One cycle per 0.1 s

  assign tick = (tk_q == 32'(TICK - 1));

  // Free running tick divider
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tk_q <= '0;
    end else if (ce) begin
      tk_q <= tick ? '0 : tk_q + 32'h1;
    end
  end

  // ****************************************
  // Pulse input synchronisers
  // ****************************************
  logic [1:0] s1_q, s2_q;   // Two stages per pin
  logic [1:0] pin;
  logic       pl_q;         // Selected level, delayed

  assign pin = {pulse_di8, pulse_di7};

  generate
    for (genvar g = 0; g < 2; g++) begin : g_sync
      // Two flip-flop synchroniser
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
        end else if (ce) begin
          s1_q[g] <= pin[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  logic psel;   // Chosen pulse level
  assign psel = (src == plm_pkg::SRC_DI7) ? s2_q[0]
              : (src == plm_pkg::SRC_DI8) ? s2_q[1] : 1'b0;

  // ****************************************
  // Period and reciprocal
  // ****************************************
  logic [23:0]          per_q;   // Cycles since last rising edge
  logic [33:0]          dvs_q;   // Period times divider
  logic [34:0]          rem_q;   // Partial remainder
  logic [31:0]          quo_q;   // Quotient
  logic [4:0]           bit_q;   // Numerator bit in work
  logic [15:0]          frq_q;   // Scaled frequency, Hz
  plm_pkg::plm_div_st_t st_q;
  logic                 rise;
  logic [34:0]          rsh;     // Remainder shifted

  assign rise = psel & ~pl_q;
  assign rsh  = {rem_q[33:0], plm_pkg::FREQ_NUM[bit_q]};

  // Period counter, saturating when pulses stop
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pl_q  <= 1'b0;
      per_q <= '0;
    end else if (ce) begin
      pl_q  <= psel;
      per_q <= rise ? 24'h1 : (&per_q ? per_q : per_q + 24'h1);
    end
  end

  // Serial divider: frequency = rate * 10 / (period * divider)
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q  <= plm_pkg::DIV_IDLE;
      dvs_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
      bit_q <= '0;
      frq_q <= '0;
    end else if (ce) begin
      // Hand over a finished quotient once, then mark it taken
      if (st_q == plm_pkg::DIV_IDLE && bit_q == 5'h0) begin
        frq_q <= |quo_q[31:16] ? 16'hffff : quo_q[15:0];
        quo_q <= '0;
        bit_q <= 5'h1f;
      end
      unique case (st_q)
        plm_pkg::DIV_IDLE: begin
          if (rise && src != plm_pkg::SRC_NONE && !(&per_q)) begin
            dvs_q <= {10'h0, per_q} * {24'h0, sdiv};
            rem_q <= '0;
            quo_q <= '0;
            bit_q <= 5'h1f;
            st_q  <= plm_pkg::DIV_RUN;
          end
        end
        plm_pkg::DIV_RUN: begin
          // One quotient bit per cycle
          if (rsh >= {1'b0, dvs_q}) begin
            rem_q <= rsh - {1'b0, dvs_q};
            quo_q <= {quo_q[30:0], 1'b1};
          end else begin
            rem_q <= rsh;
            quo_q <= {quo_q[30:0], 1'b0};
          end
          if (bit_q == 5'h0) begin
            st_q <= plm_pkg::DIV_IDLE;  // Last bit, result left in quo_q
          end else begin
            bit_q <= bit_q - 5'h1;
          end
        end
      endcase
      // No meter or no pulses reads as zero, even mid division
      if (src == plm_pkg::SRC_NONE || &per_q) begin
        frq_q <= '0;
      end
    end
  end

  // ****************************************
  // Conditions
  // ****************************************
  logic [15:0] fdiff;    // Reference minus motor, absolute
  logic        steady;
  logic [19:0] f10;      // Measured speed in 0.1 Hz
  logic [19:0] ediff;    // Estimate versus measured
  logic        meter;    // Meter configured
  logic [3:0]  tcond;    // Timed conditions
  logic [15:0] tlim [4]; // Limits in ticks
  logic [3:0]  thit;     // Condition held long enough
  logic        fbl_set;

  assign fdiff = (msr.ref_freq > msr.mot_freq) ? msr.ref_freq - msr.mot_freq
               : msr.mot_freq - msr.ref_freq;
  assign steady = fdiff < hyst;
  assign meter  = src != plm_pkg::SRC_NONE;
  assign f10    = 20'(frq_q * 10);
  assign ediff  = ({4'h0, msr.est_freq} > f10) ? {4'h0, msr.est_freq} - f10
                : f10 - {4'h0, msr.est_freq};
  // Current limit in any phase, or steady overcurrent
  assign tcond[0] = ovld_en & (msr.cur_lim
                  | (steady & (msr.mot_cur > ovld_thr)));
  assign tcond[1] = stall_en
                  & (msr.out_freq < cfg_q[plm_pkg::IX_STF][15:0])
                  & (msr.out_cur > cfg_q[plm_pkg::IX_STALL][31:16]);
  assign tcond[2] = ovs_en & meter & (frq_q > cfg_q[plm_pkg::IX_OVS][15:0]);
  assign tcond[3] = msr.brake_cfg & wear_en & meter
                  & (frq_q > cfg_q[plm_pkg::IX_WEAR][15:0]);
  assign tlim[0] = 16'(ovld_s * 10);
  assign tlim[1] = cfg_q[plm_pkg::IX_STALL][15:0];
  assign tlim[2] = cfg_q[plm_pkg::IX_OVS][31:16];
  assign tlim[3] = cfg_q[plm_pkg::IX_WEAR][31:16];
  assign fbl_set = fbl_en & meter
                 & (ediff > {4'h0, cfg_q[plm_pkg::IX_FBL][15:0]});

  // ****************************************
  // Persistence timers
  // ****************************************
  logic [15:0] tc_q [4];   // Held time, ticks

  generate
    for (genvar t = 0; t < 4; t++) begin : g_tmr
      // Count ticks while held, clear when the condition drops
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          tc_q[t] <= '0;
        end else if (ce) begin
          if (!tcond[t]) begin
            tc_q[t] <= '0;
          end else if (tick && !(&tc_q[t])) begin
            tc_q[t] <= tc_q[t] + 16'h1;
          end
        end
      end
      // Stall needs strictly longer than its limit
      assign thit[t] = tcond[t] & ((t == 1) ? (tc_q[t] > tlim[t])
                                            : (tc_q[t] >= tlim[t]));
    end
  endgenerate

  // ****************************************
  // Errors, inhibit and outputs
  // ****************************************
  logic [NERR_W-1:0] eset, eclr;
  logic [15:0]       inh_q;   // Restart inhibit left, ticks
  logic              warn;

  assign eset = {fbl_set, thit[3], thit[2], thit[1], thit[0]};
  assign eclr = (wr && idx == plm_pkg::IX_STAT && wb_sel_i[0])
              ? wb_dat_i[NERR_W-1:0] : '0;
  assign warn = meter & (frq_q > cfg_q[plm_pkg::IX_WARN][15:0]);

  // Sticky errors, a new event beats a clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      err_q <= '0;
    end else if (ce) begin
      err_q <= (err_q & ~eclr) | eset;
    end
  end

  // Restart inhibit loads on each overload detection
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      inh_q <= '0;
    end else if (ce) begin
      if (thit[0]) begin
        inh_q <= inh_lim;
      end else if (tick && inh_q != '0) begin
        inh_q <= inh_q - 16'h1;
      end
    end
  end

  // Registered fault outputs and status read data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flt   <= '0;
      dat_q <= '0;
    end else if (ce) begin
      flt.ovld    <= err_q[0];
      flt.stall   <= err_q[1];
      flt.ovs     <= err_q[2];
      flt.brake   <= err_q[3];
      flt.fbl     <= err_q[4];
      flt.warn    <= warn;
      flt.inhibit <= inh_q != '0;
      flt.stop    <= err_q[0] ? react : plm_pkg::REACT_IGNORE;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        if (wb_adr_i[7:6] != 2'h0 || idx > plm_pkg::IX_STAT) begin
          dat_q <= '0;
        end else if (idx == plm_pkg::IX_STAT) begin
          dat_q <= {frq_q, 9'h0, inh_q != '0, warn, err_q};
        end else begin
          dat_q <= cfg_q[idx];
        end
      end
    end
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = dat_q;
  assign meas_freq = frq_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_req;
    wb_cyc_i && wb_stb_i && !ack_q;
  endsequence

  property p_ack;
    @(posedge clk_sys) disable iff (!reset_n || !ce)
      s_req |=> ack_q ##1 !ack_q;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");

  property p_ovld_off;
    @(posedge clk_sys) disable iff (!reset_n)
      (ovld_s == 8'h0 && !err_q[0]) |=> !err_q[0];
  endproperty
  a_ovld_off: assert property (p_ovld_off) else $error("overload while off");

  property p_tmr_clr;
    @(posedge clk_sys) disable iff (!reset_n || !ce)
      !tcond[0] |=> tc_q[0] == 16'h0;
  endproperty
  a_tmr_clr: assert property (p_tmr_clr) else $error("timer kept count");

  property p_ovld_hold;
    @(posedge clk_sys) disable iff (!reset_n || !ce)
      eset[0] |-> tcond[0] && $past(tcond[0], 8);
  endproperty
  a_ovld_hold: assert property (p_ovld_hold) else $error("overload too early");

  property p_stall_off;
    @(posedge clk_sys) disable iff (!reset_n)
      (!stall_en && !err_q[1]) |=> !err_q[1];
  endproperty
  a_stall_off: assert property (p_stall_off) else $error("stall while off");

  property p_brake_cfg;
    @(posedge clk_sys) disable iff (!reset_n)
      (!msr.brake_cfg && !err_q[3]) |=> !err_q[3];
  endproperty
  a_brake_cfg: assert property (p_brake_cfg) else $error("brake without logic");

  property p_inhibit;
    @(posedge clk_sys) disable iff (!reset_n || !ce)
      (thit[0] && inh_lim != 16'h0) |=> ##1 flt.inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("no restart block");

  property p_stop;
    @(posedge clk_sys) disable iff (!reset_n || !ce)
      (err_q[0] && $stable(react)) |=> flt.stop == $past(react);
  endproperty
  a_stop: assert property (p_stop) else $error("wrong reaction");

  property p_meter_off;
    @(posedge clk_sys) disable iff (!reset_n || !ce)
      (src == plm_pkg::SRC_NONE) [*2] |-> frq_q == 16'h0 && !warn;
  endproperty
  a_meter_off: assert property (p_meter_off) else $error("meter without source");

endmodule

//--- core/plm_pkg.sv
/*
  Constants, register map and carrier types for the load, stall and
  pulse monitor. Assumes a single 25 MHz system clock.
*/
package plm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ   = 25_000_000;  // System clock rate
  localparam int unsigned CLK_NS   = 40;          // System clock period
  localparam int unsigned TICK_NS  = 100_000_000; // Control tick, 0.1 s
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [15:0] TPM      = 16'h0258;    // Ticks per minute
  localparam logic [31:0] FREQ_NUM = 32'(CLK_HZ * 10); // Rate with 0.1 divider

  // ****************************************
  // Register map
  // ****************************************
  localparam int NREG = 11;                       // Words in the map
  localparam logic [3:0] IX_CTRL  = 4'h0;         // Enables and selections
  localparam logic [3:0] IX_OVLD  = 4'h1;         // Overload time/thr/inhibit
  localparam logic [3:0] IX_HYST  = 4'h2;         // Steady state band
  localparam logic [3:0] IX_STALL = 4'h3;         // Stall time and current
  localparam logic [3:0] IX_STF   = 4'h4;         // Stall frequency
  localparam logic [3:0] IX_DIV   = 4'h5;         // Pulse scaling divider
  localparam logic [3:0] IX_OVS   = 4'h6;         // Overspeed thr and delay
  localparam logic [3:0] IX_FBL   = 4'h7;         // Feedback loss thr
  localparam logic [3:0] IX_WEAR  = 4'h8;         // Wear brake thr and delay
  localparam logic [3:0] IX_WARN  = 4'h9;         // Warning threshold
  localparam logic [3:0] IX_STAT  = 4'ha;         // Status, write one clears

  // Reset values of the writable words
  localparam logic [31:0] CFG_RST [10] = '{
    32'h0000_0008, 32'h0000_6e00, 32'h0000_0003, 32'h05dc_0258,
    32'h0000_0014, 32'h0000_000a, 32'h0000_7530, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000};

  // ****************************************
  // Fields
  // ****************************************
  localparam int C_STALL_EN = 0;   // Stall monitoring enable
  localparam int C_SRC      = 1;   // Pulse source, 2 bits
  localparam int C_REACT    = 3;   // Overload reaction, 2 bits
  localparam int C_OVS_EN   = 5;   // Overspeed enable
  localparam int C_FBL_EN   = 6;   // Feedback loss enable
  localparam int C_WEAR_EN  = 7;   // Wear brake enable
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_DI7  = 2'h1;
  localparam logic [1:0] SRC_DI8  = 2'h2;
  localparam logic [1:0] REACT_IGNORE = 2'h0;
  localparam int NERR = 5;         // Sticky error bits in status
  localparam int S_WARN = 5;       // Warning state in status
  localparam int S_INH  = 6;       // Restart inhibit in status
  localparam int S_FREQ = 16;      // Measured frequency in status

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        cur_lim;   // Drive in current limitation
    logic        brake_cfg; // Brake logic configured
    logic [15:0] mot_cur;   // Motor current, 0.1 % of rated
    logic [15:0] ref_freq;  // Pre-ramp reference, 0.1 Hz
    logic [15:0] mot_freq;  // Motor frequency, 0.1 Hz
    logic [15:0] out_freq;  // Output frequency, 0.1 Hz
    logic [15:0] out_cur;   // Output current, 0.1 % of rated
    logic [15:0] est_freq;  // Estimated frequency, 0.1 Hz
  } plm_msr_t;

  typedef struct packed {
    logic       ovld;       // Process overload error
    logic       stall;      // Motor stall error
    logic       ovs;        // Motor overspeed error
    logic       fbl;        // Speed feedback loss error
    logic       brake;      // Brake feedback error
    logic       warn;       // Speed warning level
    logic       inhibit;    // Automatic restart blocked
    logic [1:0] stop;       // Stop demand, reaction code
  } plm_flt_t;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN  = 2'b10
  } plm_div_st_t;

endpackage

//--- dv/plm_sensor_model.sv
/*
  Proximity sensor on an indexed disk, feeding the pulse pins.
  Assumes the bench sets the half period in ns; zero stops the disk.
*/
module plm_sensor_model (
  input  wire logic [31:0] half_ns,
  input  wire logic        use_b,
  output logic             pulse_a,
  output logic             pulse_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lvl;  // Sensor output, rests low while the disk stands

  // Free running disk, unrelated in phase to the system clock
  initial begin
    lvl = 1'b0;
    forever begin
      if (half_ns == 32'h0) begin
        lvl = 1'b0;
        #100;
      end else begin
        #(half_ns);
        lvl = ~lvl;
      end
    end
  end

  // Only the wired pin sees pulses, the other rests low
  assign pulse_a = use_b ? 1'b0 : lvl;
  assign pulse_b = use_b ? lvl : 1'b0;
endmodule

//--- dv/plm_monitor_tb.sv
/*
  Self-checking bench for the load, stall and pulse monitor.
  Assumes plm_pkg and the sensor model are compiled before it.
*/
module plm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 10;      // Cycles per control tick in this run
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic              wb_cyc  = 1'b0;
  logic              wb_stb  = 1'b0;
  logic              wb_we   = 1'b0;
  logic [3:0]        wb_sel  = 4'hf;  // Byte enables
  logic              ce      = 1'b1;  // Clock enable
  logic [7:0]        wb_adr  = 8'h00;
  logic [31:0]       wb_dat  = 32'h0;
  logic [31:0]       wb_q;       // Slave read data
  logic              wb_ack;
  logic [31:0]       q;          // Last word read
  logic [15:0]       meas_freq;
  logic [31:0]       half_ns = 32'h0;
  logic              use_b   = 1'b0;
  logic              p7;
  logic              p8;
  plm_pkg::plm_msr_t msr     = '0;
  plm_pkg::plm_flt_t flt;
  int                n_fail  = 0;
  int                checks_done = 0;
  int                seed    = 75351;
  int                p;          // Pulse period in clock cycles
  int                e;          // Random word

  always #20 clk_sys = ~clk_sys;

  plm_monitor #(.TICK(TK)) u_plm_monitor (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .msr(msr),
    .pulse_di7(p7), .pulse_di8(p8), .flt(flt), .meas_freq(meas_freq));
  plm_sensor_model u_plm_sensor_model (.half_ns(half_ns), .use_b(use_b), .pulse_a(p7),
    .pulse_b(p8));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle, held until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    chk(32'(n < 40), 32'h1);
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // Settle a few periods, then read the measured rate within one Hz
  task automatic chk_freq(input int ex);
    repeat (6 * p) @(posedge clk_sys);
    wb(1'b0, 8'h28, 32'h0);
    chk(32'(q[31:16] + 17'h1 - 17'(ex) <= 17'h2), 32'h1);
  endtask

  task automatic summarize();
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    msr.out_freq = 16'd10;
    msr.out_cur  = 16'd1600;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Reset values, then a stray write to an unmapped word
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk(q, plm_pkg::CFG_RST[i]);
    end
    wb(1'b1, 8'h40, 32'hff);
    wb(1'b0, 8'h2c, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, plm_pkg::CFG_RST[0]);
    // Byte enables: only byte one of the band word may change
    wb_sel <= 4'h2;
    wb(1'b1, 8'h08, 32'hffff_ff55);
    wb_sel <= 4'hf;
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0000_ff03);
    wb(1'b1, 8'h08, 32'h3);
    msr.cur_lim <= 1'b1;
    repeat (15 * TK) @(posedge clk_sys);
    chk(flt.ovld, 32'h0);
    msr.cur_lim <= 1'b0;
    // Each reaction code, alternating current limit and steady state
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, 8'h00, 32'(r << 3));
      wb(1'b1, 8'h04, {12'h0, (r == 3) ? 4'h1 : 4'h0, 8'h6e, 8'h01});
      wb(1'b1, 8'h28, 32'h1f);
      e = $random(seed);
      if (r % 2 == 1) begin
        msr.ref_freq <= 16'(500 + (e & 1));
        msr.mot_freq <= 16'd500;
        msr.mot_cur  <= 16'(1101 + (e & 255));
      end else begin
        msr.cur_lim <= 1'b1;
      end
      repeat (8 * TK) @(posedge clk_sys);
      chk(flt.ovld, 32'h0);
      repeat (4 * TK) @(posedge clk_sys);
      chk({flt.ovld, flt.stop, flt.stall}, {1'b1, 2'(r), 1'b0});
      msr.cur_lim <= 1'b0;
      msr.mot_cur <= 16'd0;
    end
    chk(flt.inhibit, 32'h1);
    repeat (int'(plm_pkg::TPM) * TK - 300) @(posedge clk_sys);
    chk(flt.inhibit, 32'h1);
    repeat (600) @(posedge clk_sys);
    chk(flt.inhibit, 32'h0);
    // Stall just above the current level for a 0.2 s limit
    msr.out_cur <= 16'd0;
    wb(1'b1, 8'h0c, {16'd1500, 16'd2});
    wb(1'b1, 8'h00, 32'h1);
    msr.out_cur <= 16'd1501;
    repeat (12) @(posedge clk_sys);
    chk(flt.stall, 32'h0);
    // Clock enable low freezes the stall timer
    ce <= 1'b0;
    repeat (3 * TK) @(posedge clk_sys);
    chk(flt.stall, 32'h0);
    ce <= 1'b1;
    repeat (3 * TK) @(posedge clk_sys);
    chk(flt.stall, 32'h1);
    // Pulse meter through every source choice
    e = $random(seed);
    p = 1000 + (e & 511);
    half_ns <= 32'(p * 20);
    wb(1'b1, 8'h00, 32'he0);
    wb(1'b1, 8'h28, 32'h1f);
    wb(1'b1, 8'h18, 32'(25_000_000 / p / 2));
    wb(1'b1, 8'h24, 32'(25_000_000 / p / 2));
    wb(1'b1, 8'h1c, 32'd10);
    wb(1'b1, 8'h20, 32'd1);
    for (int s = 0; s < 3; s++) begin
      use_b <= (s == 2);
      wb(1'b1, 8'h00, 32'(32'he0 | (s << 1)));
      chk_freq((s == 0) ? 0 : 25_000_000 / p);
      chk(flt.warn, 32'(s != 0));
    end
    chk({flt.ovs, flt.fbl, flt.brake}, 3'b110);
    msr.brake_cfg <= 1'b1;
    repeat (3 * TK) @(posedge clk_sys);
    wb(1'b0, 8'h28, 32'h0);
    chk(q[6:0], 7'h3c);
    wb(1'b1, 8'h14, 32'd20);
    chk_freq(25_000_000 / p / 2);
    summarize();
  end

  // Cuts a hang short well beyond the expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
endmodule
